// File: vca_pkg.sv
// ****************************************************************
// shared constants for the voice channel allocator
// ****************************************************************
package vca_pkg;

    // apb register byte offsets
    localparam logic [7:0] VCA_OFF_CTRL   = 8'h00;  // host selections
    localparam logic [7:0] VCA_OFF_CMD    = 8'h04;  // command strobes
    localparam logic [7:0] VCA_OFF_DSTART = 8'h08;  // direct start address
    localparam logic [7:0] VCA_OFF_DSTOP  = 8'h0C;  // direct stop address
    localparam logic [7:0] VCA_OFF_STATUS = 8'h10;  // live state
    localparam logic [7:0] VCA_OFF_ADDR   = 8'h14;  // last index entry

    // ctrl field positions
    localparam int VCA_CTRL_RECORDING_CONTROL_SELECT    = 0;  // recording_control_select
    localparam int VCA_CTRL_CSEL_LO = 1;  // word_count_select_low
    localparam int VCA_CTRL_CSEL_HI = 2;  // word_count_select_high
    localparam int VCA_CTRL_CH_LSB  = 3;  // channel select, 3 bits
    localparam int VCA_CTRL_SZ_LSB  = 6;  // memory size code, 3 bits
    localparam int VCA_CMD_COMMIT   = 0;  // write index entry
    localparam int VCA_ADDR_STOP_LSB = 16; // stop field in addr register

    // reset values
    localparam logic       VCA_RST_RECORDING_CONTROL_SELECT = 1'b1;
    localparam logic [1:0] VCA_RST_CSEL = 2'h0;
    localparam logic [2:0] VCA_RST_CH   = 3'h0;
    localparam logic [2:0] VCA_RST_SZ   = 3'h2;    // 1 Mbit
    localparam logic [11:0] VCA_RST_ADDR = 12'h000;

    // memory layout
    localparam logic [11:0] VCA_VOICE_BASE = 12'h008; // index area below
    localparam logic [11:0] VCA_EMPTY_STOP = 12'h007; // next start is base

    // word count shift amounts: 8, 4 and 2 words
    localparam logic [1:0] VCA_SH_8 = 2'h3;
    localparam logic [1:0] VCA_SH_4 = 2'h2;
    localparam logic [1:0] VCA_SH_2 = 2'h1;

    // control modes
    typedef enum logic [2:0] {
        VCA_MODE_DIRECT = 3'b001,
        VCA_MODE_FIXED  = 3'b010,
        VCA_MODE_FLEX   = 3'b100
    } vca_mode_e;

    // sequencer states
    typedef enum logic [2:0] {
        VCA_ST_IDLE = 3'b001,
        VCA_ST_CALC = 3'b010,
        VCA_ST_EMIT = 3'b100
    } vca_state_e;

    // highest word-direction address per size code
    function automatic logic [11:0] vca_max_addr(input logic [2:0] sz);
        case (sz)
            3'h0:    vca_max_addr = 12'h0FF; // 256 Kbit
            3'h1:    vca_max_addr = 12'h1FF; // 512 Kbit
            3'h2:    vca_max_addr = 12'h3FF; // 1 Mbit
            3'h3:    vca_max_addr = 12'h7FF; // 2 Mbit
            3'h4:    vca_max_addr = 12'hBFF; // 3 Mbit
            default: vca_max_addr = 12'hFFF; // 4 Mbit
        endcase
    endfunction

endpackage

// File: vca_calc_if.sv
`timescale 1ns/1ps
// ****************************************************************
// selections in, computed index entry out
// ****************************************************************
interface vca_calc_if;
    import vca_pkg::*;
    vca_mode_e   mode;       // latched control mode
    logic [1:0]  sh;         // log2 of word count
    logic [2:0]  chan;       // decoded channel
    logic [11:0] max_addr;   // top of memory
    logic [11:0] prev_stop;  // stop of preceding channel (flex)
    logic [11:0] dir_start;  // host supplied start (direct)
    logic [11:0] dir_stop;   // host supplied stop (direct)
    logic [11:0] start;      // resulting start address
    logic [11:0] stop;       // resulting stop address
    modport req  (output mode, sh, chan, max_addr, prev_stop, dir_start, dir_stop,
                  input start, stop);
    modport calc (input mode, sh, chan, max_addr, prev_stop, dir_start, dir_stop,
                  output start, stop);
endinterface

// File: vca_addr_calc.sv
`timescale 1ns/1ps
// ****************************************************************
// start and stop address arithmetic
// ****************************************************************
module vca_addr_calc
    import vca_pkg::*;
(
    vca_calc_if.calc c
);
    // data area size; the index words are excluded so the last fixed
    // partition never runs past the top of memory
    wire [12:0] span_w  = {1'b0, c.max_addr} + 13'h0001 - {1'b0, VCA_VOICE_BASE};
    wire [12:0] cap_w   = span_w >> c.sh;
    wire [12:0] prod_w  = 13'({10'h000, c.chan} * cap_w);
    wire [11:0] fx_st_w = VCA_VOICE_BASE + prod_w[11:0];
    wire [11:0] fx_sp_w = fx_st_w + cap_w[11:0] - 12'h001;
    // flex: ch0 at the data base, later ones just past the previous stop
    wire [11:0] fl_st_w = (c.chan == 3'h0) ? VCA_VOICE_BASE
                                          : c.prev_stop + 12'h001;

    // mode selection
    assign c.start = (c.mode == VCA_MODE_DIRECT) ? c.dir_start :
                     (c.mode == VCA_MODE_FIXED)  ? fx_st_w : fl_st_w;
    assign c.stop  = (c.mode == VCA_MODE_DIRECT) ? c.dir_stop :
                     (c.mode == VCA_MODE_FIXED)  ? fx_sp_w : c.max_addr;
endmodule

// File: vca_allocator.sv
`timescale 1ns/1ps
module vca_allocator
    import vca_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        host_mode,
    input  wire logic        word_count_select_low,
    input  wire logic        word_count_select_high,
    input  wire logic        channel_select_bit0,
    input  wire logic        channel_select_bit1,
    input  wire logic        channel_select_bit2,
    input  wire logic        powerdown_policy_pin,
    input  wire logic        alloc_req,
    input  wire logic        rec_active,
    input  wire logic        play_active,
    input  wire logic        rec_done,
    input  wire logic [11:0] rec_end_addr,
    output logic             idx_wr,
    output logic      [2:0]  idx_chan,
    output logic      [11:0] idx_start,
    output logic      [11:0] idx_stop,
    output logic             power_down,
    output logic             osc_stop
);

    // ****************************************************************
    // registers
    // ****************************************************************
    logic        recording_control_select_r;           // host recording_control_select
    logic [1:0]  csel_r;           // host word count bits
    logic [2:0]  ch_r;             // host channel command data
    logic [2:0]  sz_r;             // memory size code
    logic [11:0] dstart_r;         // direct start address
    logic [11:0] dstop_r;          // direct stop address
    vca_state_e  state_r;          // sequencer
    vca_state_e  state_nxt;
    vca_mode_e   mode_r;           // mode latched at commit
    logic [1:0]  sh_r;             // word count latched at commit
    logic [2:0]  cur_ch_r;         // channel latched at commit
    logic [11:0] stop_tbl_r [8];   // flex stop per channel
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        idx_wr_r;
    logic [2:0]  idx_chan_r;
    logic [11:0] idx_start_r;
    logic [11:0] idx_stop_r;
    logic        pd_r;
    logic        pd_nxt;

    vca_calc_if calc_if ();

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire setup_w   = psel & ~penable;                  // first bus cycle
    wire wr_w      = psel & penable & pready_r & pwrite; // write completes
    wire hit_ctrl  = (paddr == VCA_OFF_CTRL);
    wire hit_cmd   = (paddr == VCA_OFF_CMD);
    wire hit_dst   = (paddr == VCA_OFF_DSTART);
    wire hit_dsp   = (paddr == VCA_OFF_DSTOP);
    wire hit_stat  = (paddr == VCA_OFF_STATUS);
    wire hit_addr  = (paddr == VCA_OFF_ADDR);
    wire hit_any   = hit_ctrl | hit_cmd | hit_dst | hit_dsp | hit_stat | hit_addr;

    // ****************************************************************
    // selection sources
    // ****************************************************************
    // stand-alone has no recording_control_select pin: it behaves as if held high, so
    // direct mode cannot be reached without a host
    wire       recording_control_select_w = host_mode ? recording_control_select_r : 1'b1;
    wire [1:0] csel_w = host_mode ? csel_r
                        : {word_count_select_high, word_count_select_low};
    wire [2:0] raw_ch_w = host_mode ? ch_r
                          : {channel_select_bit2, channel_select_bit1,
                             channel_select_bit0};

    // control mode from the select table
    wire vca_mode_e mode_w = !recording_control_select_w          ? VCA_MODE_DIRECT :
                             (csel_w == 2'h3) ? VCA_MODE_FLEX : VCA_MODE_FIXED;
    // word count: eight unless fixed with 4 or 2 words
    wire [1:0] sh_w = (mode_w != VCA_MODE_FIXED) ? VCA_SH_8 :
                      (csel_w == 2'h1) ? VCA_SH_4 :
                      (csel_w == 2'h2) ? VCA_SH_2 : VCA_SH_8;
    // fewer words use only the upper channel bits
    wire [2:0] chan_w = (sh_w == VCA_SH_4) ? {1'b0, raw_ch_w[2:1]} :
                        (sh_w == VCA_SH_2) ? {2'b00, raw_ch_w[2]} : raw_ch_w;

    // commit request: command write under host, pin otherwise
    wire go_w = host_mode ? (wr_w & hit_cmd & pwdata[VCA_CMD_COMMIT]) : alloc_req;

    // ****************************************************************
    // address calculator
    // ****************************************************************
    assign calc_if.mode      = mode_r;
    assign calc_if.sh        = sh_r;
    assign calc_if.chan      = cur_ch_r;
    assign calc_if.max_addr  = vca_max_addr(sz_r);
    // flex relies on channels being recorded in ascending order
    assign calc_if.prev_stop = stop_tbl_r[cur_ch_r - 3'h1];
    assign calc_if.dir_start = dstart_r;
    assign calc_if.dir_stop  = dstop_r;

    vca_addr_calc u_calc (
        .c (calc_if.calc)
    );

    // ****************************************************************
    // sequencer
    // ****************************************************************
    // idle -> calc (inputs latched) -> emit (index write pulse)
    always_comb begin
        case (state_r)
            VCA_ST_IDLE: state_nxt = go_w ? VCA_ST_CALC : VCA_ST_IDLE;
            VCA_ST_CALC: state_nxt = VCA_ST_EMIT;
            VCA_ST_EMIT: state_nxt = VCA_ST_IDLE;
            default:     state_nxt = VCA_ST_IDLE;
        endcase
    end

    // power down held in reset, and in stand-alone when idle under policy low
    assign pd_nxt = !host_mode && !powerdown_policy_pin
                    && !(rec_active || play_active);

    // state register; power down holds the sequencer in idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= VCA_ST_IDLE;
        end else if (pd_r) begin
            state_r <= VCA_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // selections latched at commit so pin changes cannot tear an entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r   <= VCA_MODE_FIXED;
            sh_r     <= VCA_SH_8;
            cur_ch_r <= VCA_RST_CH;
        end else if (state_r == VCA_ST_IDLE && go_w && !pd_r) begin
            mode_r   <= mode_w;
            sh_r     <= sh_w;
            cur_ch_r <= chan_w;
        end
    end

    // index entry toward memory: fields set in calc, strobe in emit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_wr_r    <= 1'b0;
            idx_chan_r  <= VCA_RST_CH;
            idx_start_r <= VCA_RST_ADDR;
            idx_stop_r  <= VCA_RST_ADDR;
        end else begin
            idx_wr_r <= (state_r == VCA_ST_CALC) && !pd_r;
            if (state_r == VCA_ST_CALC) begin
                idx_chan_r  <= cur_ch_r;
                idx_start_r <= calc_if.start;
                idx_stop_r  <= calc_if.stop;
            end
        end
    end

    // ****************************************************************
    // flex stop table
    // ****************************************************************
    // entries keep their contents across power down like the memory
    for (genvar i = 0; i < 8; i++) begin : g_tbl
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stop_tbl_r[i] <= VCA_EMPTY_STOP;
            end else if (rec_done && mode_r == VCA_MODE_FLEX
                         && cur_ch_r == 3'(i)) begin
                stop_tbl_r[i] <= rec_end_addr;
            end
        end
    end

    // power state and oscillator gate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_r <= 1'b1;
        end else begin
            pd_r <= pd_nxt;
        end
    end

    // ****************************************************************
    // apb registers
    // ****************************************************************
    // host selection and direct address registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            recording_control_select_r   <= VCA_RST_RECORDING_CONTROL_SELECT;
            csel_r   <= VCA_RST_CSEL;
            ch_r     <= VCA_RST_CH;
            sz_r     <= VCA_RST_SZ;
            dstart_r <= VCA_RST_ADDR;
            dstop_r  <= VCA_RST_ADDR;
        end else if (wr_w) begin
            if (hit_ctrl) begin
                recording_control_select_r <= pwdata[VCA_CTRL_RECORDING_CONTROL_SELECT];
                csel_r <= pwdata[VCA_CTRL_CSEL_HI:VCA_CTRL_CSEL_LO];
                ch_r   <= pwdata[VCA_CTRL_CH_LSB +: 3];
                sz_r   <= pwdata[VCA_CTRL_SZ_LSB +: 3];
            end
            if (hit_dst) begin
                dstart_r <= pwdata[11:0];
            end
            if (hit_dsp) begin
                dstop_r <= pwdata[11:0];
            end
        end
    end

    // read mux
    wire [31:0] ctrl_rd_w = {23'h000000, sz_r, ch_r, csel_r, recording_control_select_r};
    wire [31:0] stat_rd_w = {23'h000000, pd_r, host_mode, cur_ch_r,
                             (state_r != VCA_ST_IDLE), mode_r};
    wire [31:0] addr_rd_w = {4'h0, idx_stop_r, 4'h0, idx_start_r};
    wire [31:0] rd_w = hit_ctrl ? ctrl_rd_w :
                       hit_dst  ? {20'h00000, dstart_r} :
                       hit_dsp  ? {20'h00000, dstop_r} :
                       hit_stat ? stat_rd_w :
                       hit_addr ? addr_rd_w : 32'h00000000;

    // one wait-free access phase: ready rises on the edge that ends the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= setup_w;
            pslverr_r <= setup_w & ~hit_any;
            prdata_r  <= (setup_w & ~pwrite) ? rd_w : 32'h00000000;
        end
    end

    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign idx_wr     = idx_wr_r;
    assign idx_chan   = idx_chan_r;
    assign idx_start  = idx_start_r;
    assign idx_stop   = idx_stop_r;
    assign power_down = pd_r;
    assign osc_stop   = pd_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_commit;
        state_r == VCA_ST_IDLE && go_w && !pd_r;
    endsequence
    sequence s_emit;
        !idx_wr ##1 idx_wr ##1 !idx_wr;
    endsequence

    a_commit_emit_time: assert property (s_commit ##1 !pd_r |-> s_emit)
        else $error("index write not two cycles after commit");
    a_direct_host_only: assert property (
        (s_commit and (mode_w == VCA_MODE_DIRECT)) |-> host_mode && !recording_control_select_r)
        else $error("direct mode without host");
    a_flex_ch0_base: assert property (
        idx_wr && mode_r == VCA_MODE_FLEX && idx_chan == 3'h0
        |-> idx_start == 12'h008 && idx_stop == vca_max_addr(sz_r))
        else $error("flex ch0 entry wrong");
    a_flex_next_start: assert property (
        idx_wr && mode_r == VCA_MODE_FLEX && idx_chan != 3'h0
        |-> idx_start == stop_tbl_r[idx_chan - 3'h1] + 12'h001)
        else $error("flex start not past previous stop");
    a_fixed_span: assert property (
        idx_wr && mode_r == VCA_MODE_FIXED |-> 13'(idx_stop - idx_start) + 13'h0001
        == ((13'(vca_max_addr(sz_r)) - 13'h0007) >> sh_r))
        else $error("fixed share size wrong");
    a_fixed_ch_range: assert property (
        idx_wr && mode_r == VCA_MODE_FIXED |-> idx_chan < (4'h1 << sh_r))
        else $error("fixed channel beyond word count");
    a_pd_auto_idle: assert property (
        !host_mode && !powerdown_policy_pin && !rec_active && !play_active
        |=> power_down && osc_stop)
        else $error("no automatic power down while idle");
    // the release edge still shows the reset level of power_down, so the
    // window only opens once reset has been seen high
    a_pd_policy_high: assert property (
        presetn && powerdown_policy_pin ##1 powerdown_policy_pin |-> !power_down)
        else $error("powered down while policy high");
    a_direct_entry: assert property (
        idx_wr && mode_r == VCA_MODE_DIRECT |-> idx_start == dstart_r
        && idx_stop == dstop_r)
        else $error("direct entry not host value");

endmodule

// File: vca_mem_model.sv
`timescale 1ns/1ps
// ****************************************************************
// serial register model: channel index area as the allocator fills it
// ****************************************************************
module vca_mem_model (
    input  wire logic        pclk,
    input  wire logic        idx_wr,
    input  wire logic [2:0]  idx_chan,
    input  wire logic [11:0] idx_start,
    input  wire logic [11:0] idx_stop,
    input  wire logic [2:0]  q_chan,
    output logic      [11:0] q_start,
    output logic      [11:0] q_stop
);
    logic [11:0] start_mem [0:7];  // header words 000h-007h
    logic [11:0] stop_mem  [0:7];  // tail part of each header word
    // a blank part reads all ones; device reset does not clear memory
    initial begin
        for (int i = 0; i < 8; i++) begin
            start_mem[i] = 12'hFFF;
            stop_mem[i] = 12'hFFF;
        end
    end
    // store an entry on each write pulse
    always @(posedge pclk) begin
        if (idx_wr === 1'b1) begin
            start_mem[idx_chan] <= idx_start;
            stop_mem[idx_chan] <= idx_stop;
        end
    end
    assign q_start = start_mem[q_chan];  // readback of one header word
    assign q_stop  = stop_mem[q_chan];
endmodule

// File: vca_allocator_tb.sv
`timescale 1ns/1ps
module vca_allocator_tb;
    import vca_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;  // apb side
    logic [7:0]  paddr;                                     // byte address
    logic [31:0] pwdata, prdata, rd;                        // data words
    logic        err, got, host_mode, pol, alloc_req, rec_active, play_active;
    logic        rec_done, idx_wr, power_down, osc_stop;    // handshakes
    logic [1:0]  ws;                                        // word count pins {high,low}
    logic [2:0]  pins, idx_chan, q_chan, ch, pat;           // channel selects
    logic [11:0] rec_end_addr, idx_start, idx_stop, q_start, q_stop, sh, st;
    logic [11:0] tops [0:5];                                // top address per size code
    int          errors, checks;                            // tallies
    vca_allocator dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_mode(host_mode), .word_count_select_low(ws[0]),
        .word_count_select_high(ws[1]), .channel_select_bit0(pins[0]),
        .channel_select_bit1(pins[1]), .channel_select_bit2(pins[2]),
        .powerdown_policy_pin(pol), .alloc_req(alloc_req), .rec_active(rec_active),
        .play_active(play_active), .rec_done(rec_done), .rec_end_addr(rec_end_addr),
        .idx_wr(idx_wr), .idx_chan(idx_chan), .idx_start(idx_start), .idx_stop(idx_stop),
        .power_down(power_down), .osc_stop(osc_stop));
    vca_mem_model mem_u (.pclk(pclk), .idx_wr(idx_wr), .idx_chan(idx_chan),
        .idx_start(idx_start), .idx_stop(idx_stop), .q_chan(q_chan), .q_start(q_start),
        .q_stop(q_stop));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            errors++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // bounded wait for an index write pulse
    task automatic wait_entry();
        got = 1'b0;
        for (int i = 0; i < 8 && !got; i++) begin
            @(posedge pclk);
            got = (idx_wr === 1'b1);
        end
    endtask
    // entry must appear, on the pins and in the modelled index area
    task automatic expect_entry(input logic [2:0] c, input logic [11:0] s, input logic [11:0] e);
        wait_entry();
        if (!got) begin
            errors++;
            summarize();
        end
        check(idx_chan, c);
        #1 q_chan = c;
        #1 check(q_start, s);
        check(q_stop, e);
    endtask
    // stand-alone commit: one-cycle request with selections set alongside
    task automatic pulse(input logic [1:0] w, input logic [2:0] p);
        @(posedge pclk);
        ws <= w;
        pins <= p;
        alloc_req <= 1'b1;
        @(posedge pclk);
        alloc_req <= 1'b0;
    endtask
    // ****************************************************************
    // clock and main sequence
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, alloc_req, rec_active, play_active, rec_done} = '0;
        {paddr, pwdata, ws, pins, rec_end_addr, q_chan} = '0;
        host_mode = 1'b1;
        pol = 1'b1;
        errors = 0;
        checks = 0;
        tops = '{12'h0FF, 12'h1FF, 12'h3FF, 12'h7FF, 12'hBFF, 12'hFFF};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, VCA_OFF_CTRL, 32'h0);
        check(rd, 32'h0000_0081);
        apb(1'b0, 8'h3C, 32'h0);   // unmapped place
        check({31'h0, err}, 32'h1);
        check(power_down, 1'b0);
        // host direct: channel 5 gets the host's own addresses
        apb(1'b1, VCA_OFF_CTRL, 32'h0000_00A8);
        apb(1'b1, VCA_OFF_DSTART, 32'h0000_0200);
        apb(1'b1, VCA_OFF_DSTOP, 32'h0000_02FF);
        apb(1'b1, VCA_OFF_CMD, 32'h1);
        expect_entry(3'h5, 12'h200, 12'h2FF);
        // last entry and latched selections read back over the bus
        apb(1'b0, VCA_OFF_ADDR, 32'h0);
        check(rd, 32'h02FF_0200);
        apb(1'b0, VCA_OFF_STATUS, 32'h0);
        check(rd, 32'h0000_00D1);
        // host flex channel 0 for every memory size
        for (int s = 0; s < 6; s++) begin
            apb(1'b1, VCA_OFF_CTRL, 32'h7 | (s << 6));
            apb(1'b1, VCA_OFF_CMD, 32'h1);
            expect_entry(3'h0, 12'h008, tops[s]);
        end
        apb(1'b1, VCA_OFF_CTRL, 32'h0000_0080);  // recording_control_select low must not reach stand-alone
        // stand-alone fixed: each word count, two pin patterns
        host_mode <= 1'b0;
        for (int w = 0; w < 3; w++) begin
            for (int k = 0; k < 2; k++) begin
                pat = k ? 3'b101 : 3'b111;
                ch = (w == 0) ? pat : (w == 1) ? {1'b0, pat[2:1]} : {2'b00, pat[2]};
                sh = (w == 0) ? 12'h07F : (w == 1) ? 12'h0FE : 12'h1FC;
                st = 12'h008 + ch * sh;
                pulse(w[1:0], pat);
                expect_entry(ch, st, st + sh - 12'h001);
            end
        end
        // stand-alone flex: channel 1 follows the stored stop of channel 0
        pulse(2'b11, 3'b000);
        expect_entry(3'h0, 12'h008, 12'h3FF);
        @(posedge pclk);
        rec_done <= 1'b1;
        rec_end_addr <= 12'h100;
        @(posedge pclk);
        rec_done <= 1'b0;
        pulse(2'b11, 3'b001);
        expect_entry(3'h1, 12'h101, 12'h3FF);
        // policy low: idle powers down, activity wakes
        @(posedge pclk);
        pol <= 1'b0;
        repeat (3) @(posedge pclk);
        check({power_down, osc_stop}, 2'b11);
        pulse(2'b00, 3'b000);
        wait_entry();
        check(got, 1'b0);
        rec_active <= 1'b1;
        repeat (3) @(posedge pclk);
        check(power_down, 1'b0);
        {rec_active, play_active} <= 2'b01;
        repeat (3) @(posedge pclk);
        check(power_down, 1'b0);
        play_active <= 1'b0;
        pol <= 1'b1;
        repeat (3) @(posedge pclk);
        check(power_down, 1'b0);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        check({power_down, osc_stop}, 2'b11);
        summarize();
    end
endmodule
